// ### design/flash_segment_code_protection.sv
`timescale 1ns/1ps
// Overview of operation
// - Flash splits into boot, general and configuration segments; boot most privileged.
// - Boot code may reach other segments with few restrictions.
// - Configuration segment holds config data at the top of flash.
// - Each segment has code-protect and write-protect bits from config.
// - Boot size is a 13-bit page count of 1024-word pages.
// - Minimum boot segment is one page: vector table plus 512 code words.
// - Alternate vector table takes the last boot page; minimum two pages.
// - Boot write protection does not cover the alternate vector table.
// - With the alternate table on, boot code may program or erase the last boot page, except in partition 1 of protected modes.
// - General segment follows boot segment up to the configuration words.
// - Primary vector table reads use general code protection only without boot segment.
// - Primary vector table cannot be written if either segment is write-protected.
// - No segment is mandatory; general may be protected alone.
// - Dual partition: each partition gets its own segments and vectors.
// - No fetch from inactive partition; read/program it under its protection.
// - Protected dual partition: partition 1 never erased or written.
// - Privileged mode adds boot/general cross-access restrictions to protected mode.
module flash_segment_code_protection
   import flash_prot_pkg::*;
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [7:0] SECURITY_CONFIG_WORD,
   input wire logic [PAGE_W-1:0] BOOT_PAGE_COUNT,
   input wire flash_prot_pkg::part_mode_e PART_MODE,
   input wire logic ACTIVE_PARTITION,
   input wire flash_prot_pkg::req_s REQ,
   output logic GRANT,
   output logic DENY,
   output flash_prot_pkg::seg_e SEGMENT,
   output logic CFG_LOADED
);
   import flash_prot_pkg::*;

   cfg_s cfg_in, cfg;
   logic loaded;
   logic [PAGE_W-1:0] pages_eff;
   logic [ADDR_W-1:0] boot_end, cfg_start;
   seg_e seg;
   logic in_alt, in_vec;
   logic boot_en, alt_en;
   logic is_write, is_read, from_boot;
   logic inactive, dual, protect1;
   logic allow;
   logic grant_reg, grant_next, deny_reg, deny_next;
   seg_e seg_reg, seg_next;

   assign cfg_in = '{sec: SECURITY_CONFIG_WORD, boot_page_count: BOOT_PAGE_COUNT,
                     part_mode: PART_MODE, active_partition: ACTIVE_PARTITION};

   flash_cfg_latch u_latch (
      .clk(CLK),
      .rstn(RSTN),
      .cfg_in(cfg_in),
      .cfg_out(cfg),
      .loaded(loaded)
   );

   assign boot_en = cfg.sec[SEC_BOOT_EN];
   assign alt_en = boot_en && cfg.sec[SEC_ALT_EN];

   always_comb begin
      pages_eff = cfg.boot_page_count;
      if (!boot_en) begin
         pages_eff = '0;
      end else if (alt_en && pages_eff < BOOT_PAGES_MIN_ALT) begin
         pages_eff = BOOT_PAGES_MIN_ALT;
      end else if (pages_eff < BOOT_PAGES_MIN) begin
         pages_eff = BOOT_PAGES_MIN;
      end
      boot_end = ADDR_W'({pages_eff, {PAGE_SHIFT{1'b0}}});
      cfg_start = FLASH_WORDS_DEF - CFG_WORDS_DEF;
   end

   flash_seg_decode u_dec (
      .addr(REQ.addr),
      .boot_end(boot_end),
      .cfg_start(cfg_start),
      .alt_en(alt_en),
      .seg(seg),
      .in_alt(in_alt),
      .in_vec(in_vec)
   );

   assign is_write = REQ.op == OP_PROG || REQ.op == OP_ERASE;
   assign is_read = REQ.op == OP_READ;
   assign from_boot = REQ.src_seg == SEG_BOOT || REQ.src_seg == SEG_VEC;
   assign dual = cfg.part_mode != PART_SINGLE;
   assign inactive = dual && REQ.partition != cfg.active_partition;
   assign protect1 = (cfg.part_mode == PART_PROTECTED || cfg.part_mode == PART_PRIVILEGED)
                     && REQ.partition;

   always_comb begin
      allow = 1'b1;
      unique case (seg)
         SEG_BOOT: begin
            if (is_write && cfg.sec[SEC_BOOT_WP] && !in_alt) begin
               allow = 1'b0;
            end
            if (is_read && cfg.sec[SEC_BOOT_CP] && !from_boot) begin
               allow = 1'b0;
            end
            if (is_write && in_alt && from_boot) begin
               allow = 1'b1;
            end
         end
         SEG_GEN: begin
            if (is_write && cfg.sec[SEC_GEN_WP]) begin
               allow = 1'b0;
            end
            if (is_read && cfg.sec[SEC_GEN_CP] && REQ.src_seg == SEG_CFG) begin
               allow = 1'b0;
            end
            if (cfg.part_mode == PART_PRIVILEGED && is_write && from_boot &&
                cfg.sec[SEC_GEN_CP]) begin
               allow = 1'b0;
            end
         end
         SEG_CFG: begin
            if (is_write && cfg.sec[SEC_CFG_WP]) begin
               allow = 1'b0;
            end
            if (is_read && cfg.sec[SEC_CFG_CP] && !from_boot) begin
               allow = 1'b0;
            end
            if (REQ.op == OP_EXEC) begin
               allow = 1'b0;
            end
         end
         SEG_VEC: begin
            if (is_write && (cfg.sec[SEC_BOOT_WP] || cfg.sec[SEC_GEN_WP])) begin
               allow = 1'b0;
            end
            if (is_read && !from_boot &&
                (boot_en ? cfg.sec[SEC_BOOT_CP] : cfg.sec[SEC_GEN_CP])) begin
               allow = 1'b0;
            end
         end
      endcase
      if (cfg.part_mode == PART_PRIVILEGED && seg == SEG_BOOT && !from_boot && is_write) begin
         allow = 1'b0;
      end
      if (inactive && REQ.op == OP_EXEC) begin
         allow = 1'b0;
      end
      if (protect1 && is_write) begin
         allow = 1'b0;
      end
      if (!loaded) begin
         allow = 1'b0;
      end
   end

   always_comb begin
      grant_next = REQ.valid && allow;
      deny_next = REQ.valid && !allow;
      seg_next = REQ.valid ? seg : seg_reg;
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         grant_reg <= 1'b0;
         deny_reg <= 1'b0;
         seg_reg <= SEG_BOOT;
      end else begin
         grant_reg <= grant_next;
         deny_reg <= deny_next;
         seg_reg <= seg_next;
      end
   end

   assign GRANT = grant_reg;
   assign DENY = deny_reg;
   assign SEGMENT = seg_reg;
   assign CFG_LOADED = loaded;

   property p_exclusive;
      @(posedge CLK) disable iff (!RSTN) !(GRANT && DENY);
   endproperty
   a_exclusive: assert property (p_exclusive) else $error("grant and deny together");

   property p_answer;
      @(posedge CLK) disable iff (!RSTN) REQ.valid && loaded |=> (GRANT || DENY);
   endproperty
   a_answer: assert property (p_answer) else $error("request not answered");

   property p_no_inactive_fetch;
      @(posedge CLK) disable iff (!RSTN) REQ.valid && inactive && REQ.op == OP_EXEC |=> DENY;
   endproperty
   a_no_inactive_fetch: assert property (p_no_inactive_fetch) else $error("inactive fetch");

   property p_part1_locked;
      @(posedge CLK) disable iff (!RSTN) REQ.valid && protect1 && is_write |=> !GRANT;
   endproperty
   a_part1_locked: assert property (p_part1_locked) else $error("partition 1 written");

   property p_vec_wp;
      @(posedge CLK) disable iff (!RSTN)
         REQ.valid && seg == SEG_VEC && is_write && cfg.sec[SEC_GEN_WP] |=> DENY;
   endproperty
   a_vec_wp: assert property (p_vec_wp) else $error("vector table written");

   property p_alt_free;
      @(posedge CLK) disable iff (!RSTN)
         REQ.valid && loaded && in_alt && from_boot && is_write && !protect1 &&
         !inactive && cfg.part_mode != PART_PRIVILEGED |=> GRANT;
   endproperty
   a_alt_free: assert property (p_alt_free) else $error("last boot page blocked");

   property p_cfg_stable;
      @(posedge CLK) disable iff (!RSTN) loaded && $past(loaded) |-> $stable(cfg);
   endproperty
   a_cfg_stable: assert property (p_cfg_stable) else $error("config changed");

   property p_boot_min;
      @(posedge CLK) disable iff (!RSTN) boot_en |-> boot_end >= ADDR_W'(1 << PAGE_SHIFT);
   endproperty
   a_boot_min: assert property (p_boot_min) else $error("boot segment too small");

   property p_boot_wp;
      @(posedge CLK) disable iff (!RSTN)
         REQ.valid && seg == SEG_BOOT && is_write && cfg.sec[SEC_BOOT_WP] && !in_alt |=> DENY;
   endproperty
   a_boot_wp: assert property (p_boot_wp) else $error("boot segment written");

   property p_gen_wp;
      @(posedge CLK) disable iff (!RSTN)
         REQ.valid && seg == SEG_GEN && is_write && cfg.sec[SEC_GEN_WP] |=> DENY;
   endproperty
   a_gen_wp: assert property (p_gen_wp) else $error("general segment written");

   property p_cfg_wp;
      @(posedge CLK) disable iff (!RSTN)
         REQ.valid && seg == SEG_CFG && is_write && cfg.sec[SEC_CFG_WP] |=> DENY;
   endproperty
   a_cfg_wp: assert property (p_cfg_wp) else $error("configuration segment written");

   property p_cfg_noexec;
      @(posedge CLK) disable iff (!RSTN)
         REQ.valid && seg == SEG_CFG && REQ.op == OP_EXEC |=> DENY;
   endproperty
   a_cfg_noexec: assert property (p_cfg_noexec) else $error("configuration executed");

   property p_boot_cp;
      @(posedge CLK) disable iff (!RSTN)
         REQ.valid && seg == SEG_BOOT && is_read && cfg.sec[SEC_BOOT_CP] && !from_boot |=> DENY;
   endproperty
   a_boot_cp: assert property (p_boot_cp) else $error("boot segment read");

   property p_vec_boot_wp;
      @(posedge CLK) disable iff (!RSTN)
         REQ.valid && seg == SEG_VEC && is_write && cfg.sec[SEC_BOOT_WP] |=> DENY;
   endproperty
   a_vec_boot_wp: assert property (p_vec_boot_wp) else $error("vector table written");

   property p_vec_gen_cp;
      @(posedge CLK) disable iff (!RSTN)
         REQ.valid && seg == SEG_VEC && is_read && !from_boot && !boot_en &&
         cfg.sec[SEC_GEN_CP] |=> DENY;
   endproperty
   a_vec_gen_cp: assert property (p_vec_gen_cp) else $error("vector table read");

   property p_priv_boot;
      @(posedge CLK) disable iff (!RSTN)
         REQ.valid && cfg.part_mode == PART_PRIVILEGED && seg == SEG_BOOT && !from_boot &&
         is_write |=> DENY;
   endproperty
   a_priv_boot: assert property (p_priv_boot) else $error("boot written by general");

   property p_priv_gen;
      @(posedge CLK) disable iff (!RSTN)
         REQ.valid && cfg.part_mode == PART_PRIVILEGED && seg == SEG_GEN && from_boot &&
         is_write && cfg.sec[SEC_GEN_CP] |=> DENY;
   endproperty
   a_priv_gen: assert property (p_priv_gen) else $error("general written by boot");

   property p_not_loaded;
      @(posedge CLK) disable iff (!RSTN)
         REQ.valid && !loaded |=> DENY;
   endproperty
   a_not_loaded: assert property (p_not_loaded) else $error("request before load");

   property p_idle_quiet;
      @(posedge CLK) disable iff (!RSTN)
         !REQ.valid |=> !GRANT && !DENY;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("answer without request");

   property p_seg_hold;
      @(posedge CLK) disable iff (!RSTN)
         !REQ.valid |=> $stable(SEGMENT);
   endproperty
   a_seg_hold: assert property (p_seg_hold) else $error("segment changed while idle");

   property p_seg_update;
      @(posedge CLK) disable iff (!RSTN)
         REQ.valid |=> SEGMENT == $past(seg);
   endproperty
   a_seg_update: assert property (p_seg_update) else $error("segment not reported");

   property p_alt_min;
      @(posedge CLK) disable iff (!RSTN)
         alt_en |-> boot_end >= ADDR_W'(int'(BOOT_PAGES_MIN_ALT) << PAGE_SHIFT);
   endproperty
   a_alt_min: assert property (p_alt_min) else $error("boot segment below two pages");

   property p_no_boot;
      @(posedge CLK) disable iff (!RSTN)
         !boot_en |-> boot_end == '0;
   endproperty
   a_no_boot: assert property (p_no_boot) else $error("boot segment without enable");

   c_grant: cover property (@(posedge CLK) disable iff (!RSTN) GRANT);
   c_deny: cover property (@(posedge CLK) disable iff (!RSTN) DENY);
   c_alt: cover property (@(posedge CLK) disable iff (!RSTN) REQ.valid && in_alt);
   c_inactive_fetch: cover property (@(posedge CLK) disable iff (!RSTN)
      REQ.valid && inactive && REQ.op == OP_EXEC);
   c_vec_write: cover property (@(posedge CLK) disable iff (!RSTN)
      REQ.valid && seg == SEG_VEC && is_write);
endmodule

// ### design/flash_prot_pkg.sv
package flash_prot_pkg;
   localparam int ADDR_W = 24;
   localparam int PAGE_W = 13;
   localparam int PAGE_SHIFT = 10;
   localparam int BOOT_CODE_OFS = 512;
   localparam logic [PAGE_W-1:0] BOOT_PAGES_MIN = 13'h0001;
   localparam logic [PAGE_W-1:0] BOOT_PAGES_MIN_ALT = 13'h0002;
   localparam logic [ADDR_W-1:0] FLASH_WORDS_DEF = 24'h020000;
   localparam logic [ADDR_W-1:0] CFG_WORDS_DEF = 24'h000400;
   localparam int SEC_BOOT_WP = 0;
   localparam int SEC_BOOT_CP = 1;
   localparam int SEC_GEN_WP = 2;
   localparam int SEC_GEN_CP = 3;
   localparam int SEC_CFG_WP = 4;
   localparam int SEC_CFG_CP = 5;
   localparam int SEC_BOOT_EN = 6;
   localparam int SEC_ALT_EN = 7;
   localparam logic [7:0] SEC_RESET = 8'h00;

   typedef enum logic [1:0] {
      OP_READ = 2'b00,
      OP_EXEC = 2'b01,
      OP_PROG = 2'b10,
      OP_ERASE = 2'b11
   } op_e;

   typedef enum logic [1:0] {
      PART_SINGLE = 2'b00,
      PART_DUAL = 2'b01,
      PART_PROTECTED = 2'b10,
      PART_PRIVILEGED = 2'b11
   } part_mode_e;

   typedef enum logic [1:0] {
      SEG_BOOT = 2'b00,
      SEG_GEN = 2'b01,
      SEG_CFG = 2'b10,
      SEG_VEC = 2'b11
   } seg_e;

   typedef struct packed {
      logic valid;
      op_e op;
      logic partition;
      logic [ADDR_W-1:0] addr;
      seg_e src_seg;
   } req_s;

   typedef struct packed {
      logic [7:0] sec;
      logic [PAGE_W-1:0] boot_page_count;
      part_mode_e part_mode;
      logic active_partition;
   } cfg_s;
endpackage

// ### design/flash_cfg_latch.sv
`timescale 1ns/1ps
module flash_cfg_latch
   import flash_prot_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire cfg_s cfg_in,
   output cfg_s cfg_out,
   output logic loaded
);
   cfg_s cfg_reg, cfg_next;
   logic loaded_reg, loaded_next;

   always_comb begin
      cfg_next = cfg_reg;
      loaded_next = 1'b1;
      if (!loaded_reg) begin
         cfg_next = cfg_in;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cfg_reg <= '{sec: SEC_RESET, boot_page_count: '0, part_mode: PART_SINGLE,
                      active_partition: 1'b0};
         loaded_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         loaded_reg <= loaded_next;
      end
   end

   assign cfg_out = cfg_reg;
   assign loaded = loaded_reg;
endmodule

// ### design/flash_seg_decode.sv
`timescale 1ns/1ps
module flash_seg_decode
   import flash_prot_pkg::*;
(
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [ADDR_W-1:0] boot_end,
   input wire logic [ADDR_W-1:0] cfg_start,
   input wire logic alt_en,
   output seg_e seg,
   output logic in_alt,
   output logic in_vec
);
   logic [ADDR_W-1:0] last_page;

   always_comb begin
      last_page = boot_end - ADDR_W'(1 << PAGE_SHIFT);
      in_vec = addr < ADDR_W'(BOOT_CODE_OFS);
      in_alt = alt_en && addr >= last_page && addr < boot_end;
      if (addr >= cfg_start) begin
         seg = SEG_CFG;
      end else if (in_vec) begin
         seg = SEG_VEC;
      end else if (addr < boot_end) begin
         seg = SEG_BOOT;
      end else begin
         seg = SEG_GEN;
      end
   end
endmodule

// ### test/flash_requester.sv
`timescale 1ns/1ps
module flash_requester
   import flash_prot_pkg::*;
(
   input wire logic clk,
   output req_s req
);
   initial begin
      req = '0;
   end
   // One request, held up to the taking edge only
   task automatic send(input op_e op, input logic part, input logic [ADDR_W-1:0] addr,
         input seg_e src);
      @(posedge clk);
      req <= '{valid: 1'b1, op: op, partition: part, addr: addr, src_seg: src};
      @(posedge clk);
      req.valid <= 1'b0;
      req.addr <= ~addr;
   endtask
endmodule

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
   import flash_prot_pkg::*;
   logic clk;
   logic rstn;
   logic [7:0] sec;
   logic [PAGE_W-1:0] pages;
   part_mode_e mode;
   logic act;
   req_s req;
   logic grant;
   logic deny;
   seg_e seg;
   logic loaded;
   int failures = 0;
   int compares = 0;

   flash_segment_code_protection dut (.CLK(clk), .RSTN(rstn), .SECURITY_CONFIG_WORD(sec),
      .BOOT_PAGE_COUNT(pages), .PART_MODE(mode), .ACTIVE_PARTITION(act), .REQ(req),
      .GRANT(grant), .DENY(deny), .SEGMENT(seg), .CFG_LOADED(loaded));
   flash_requester requester (.clk(clk), .req(req));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic cmp_bit(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %s is %b", $time, what, got);
      end
   endtask

   task automatic cmp_seg(input seg_e exp);
      compares++;
      if (seg !== exp) begin
         failures++;
         $display("unexpected at %0t: segment is %b", $time, seg);
      end
   endtask

   task automatic acc(input op_e op, input logic p, input logic [ADDR_W-1:0] a,
         input seg_e src, input logic ok);
      requester.send(op, p, a, src);
      #1;
      cmp_bit(grant, ok, "grant");
      cmp_bit(deny, !ok, "deny");
   endtask

   task automatic restart(input logic [7:0] s, input logic [PAGE_W-1:0] p,
         input part_mode_e m, input logic a);
      @(posedge clk);
      rstn <= 1'b0;
      sec <= s;
      pages <= p;
      mode <= m;
      act <= a;
      @(posedge clk);
      #1;
      cmp_bit(loaded, 1'b0, "loaded in reset");
      @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      cmp_bit(loaded, 1'b1, "loaded");
   endtask

   task automatic t_boot();
      restart(8'h41, 13'h0002, PART_SINGLE, 1'b0);
      acc(OP_PROG, 1'b0, 24'h000500, SEG_GEN, 1'b0);
      cmp_seg(SEG_BOOT);
      acc(OP_ERASE, 1'b0, 24'h0007FF, SEG_GEN, 1'b0);
      acc(OP_PROG, 1'b0, 24'h000800, SEG_GEN, 1'b1);
      cmp_seg(SEG_GEN);
      acc(OP_READ, 1'b0, 24'h000500, SEG_GEN, 1'b1);
      $display("boot segment test done");
   endtask

   task automatic t_alt();
      restart(8'hC1, 13'h0002, PART_SINGLE, 1'b0);
      acc(OP_PROG, 1'b0, 24'h000400, SEG_BOOT, 1'b1);
      acc(OP_ERASE, 1'b0, 24'h0007FF, SEG_GEN, 1'b1);
      acc(OP_PROG, 1'b0, 24'h0003FF, SEG_GEN, 1'b0);
      $display("alternate table test done");
   endtask

   task automatic t_vec();
      restart(8'h44, 13'h0001, PART_SINGLE, 1'b0);
      acc(OP_PROG, 1'b0, 24'h000100, SEG_BOOT, 1'b0);
      cmp_seg(SEG_VEC);
      acc(OP_ERASE, 1'b0, 24'h0001FF, SEG_BOOT, 1'b0);
      acc(OP_READ, 1'b0, 24'h000100, SEG_BOOT, 1'b1);
      acc(OP_PROG, 1'b0, 24'h000300, SEG_BOOT, 1'b1);
      restart(8'h41, 13'h0001, PART_SINGLE, 1'b0);
      acc(OP_PROG, 1'b0, 24'h000100, SEG_BOOT, 1'b0);
      $display("vector table test done");
   endtask

   task automatic t_noboot();
      restart(8'h08, 13'h0002, PART_SINGLE, 1'b0);
      acc(OP_READ, 1'b0, 24'h000500, SEG_GEN, 1'b1);
      cmp_seg(SEG_GEN);
      acc(OP_READ, 1'b0, 24'h001000, SEG_CFG, 1'b0);
      acc(OP_READ, 1'b0, 24'h000100, SEG_CFG, 1'b0);
      acc(OP_READ, 1'b0, 24'h000100, SEG_GEN, 1'b0);
      $display("no boot segment test done");
   endtask

   task automatic t_cfg();
      restart(8'h10, 13'h0001, PART_SINGLE, 1'b0);
      acc(OP_PROG, 1'b0, 24'h01FC00, SEG_GEN, 1'b0);
      cmp_seg(SEG_CFG);
      acc(OP_PROG, 1'b0, 24'h01FBFF, SEG_GEN, 1'b1);
      cmp_seg(SEG_GEN);
      acc(OP_EXEC, 1'b0, 24'h01FC10, SEG_GEN, 1'b0);
      $display("configuration segment test done");
   endtask

   task automatic t_dual();
      for (int a = 0; a < 2; a++) begin
         restart(8'h00, 13'h0001, PART_DUAL, a[0]);
         acc(OP_EXEC, !a[0], 24'h001000, SEG_GEN, 1'b0);
         acc(OP_EXEC, a[0], 24'h001000, SEG_GEN, 1'b1);
         acc(OP_READ, !a[0], 24'h001000, SEG_GEN, 1'b1);
         acc(OP_PROG, !a[0], 24'h001000, SEG_GEN, 1'b1);
      end
      $display("dual partition test done");
   endtask

   task automatic t_prot();
      part_mode_e m;
      for (int i = 0; i < 2; i++) begin
         m = (i == 0) ? PART_PROTECTED : PART_PRIVILEGED;
         restart(8'h48, 13'h0001, m, 1'b0);
         acc(OP_PROG, 1'b1, 24'h001000, SEG_GEN, 1'b0);
         acc(OP_ERASE, 1'b1, 24'h001000, SEG_GEN, 1'b0);
         acc(OP_PROG, 1'b0, 24'h001000, SEG_GEN, 1'b1);
         acc(OP_PROG, 1'b0, 24'h000300, SEG_GEN, i == 0);
         acc(OP_PROG, 1'b0, 24'h001000, SEG_BOOT, i == 0);
      end
      $display("protected partition test done");
   endtask

   task automatic t_latch();
      restart(8'h00, 13'h0001, PART_SINGLE, 1'b0);
      @(posedge clk);
      sec <= 8'hFF;
      acc(OP_PROG, 1'b0, 24'h001000, SEG_GEN, 1'b1);
      acc(OP_READ, 1'b0, 24'h000300, SEG_GEN, 1'b1);
      $display("config latch test done");
   endtask

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      rstn = 1'b0;
      sec = 8'h00;
      pages = 13'h0001;
      mode = PART_SINGLE;
      act = 1'b0;
      t_boot();
      t_alt();
      t_vec();
      t_noboot();
      t_cfg();
      t_dual();
      t_prot();
      t_latch();
      wrap_up();
   end

   initial begin
      #20000;
      failures++;
      wrap_up();
   end
endmodule
